// File: mmu_pkg.sv
// Behaviour
// - Reset clears enable bits of control and both windows; cache kept.
// - Register writes other than status flush the whole cache unless flush inhibit is set.
// - Register move reads or writes all six MMU registers.
// - Enabled control write checks index, page and shift sum equals 32.
// - Page size codes zero to seven raise the configuration exception.
// - Root pointer with descriptor type zero is stored, then exception raised.
// - Invalidate all entries, entries of one code, or one code and address.
// - Preload walks tables, drops the old entry, installs the new one.
// - Write preload marks used and modified; read preload marks used only.
// - Preload leaves the status register unchanged.
// - Probe searches cache or tables, sets status; table probes return descriptor address.
// - Probe never changes the translation cache.
// - Probe level seven walks to the bottom, at most five levels.
// - Read and write probes agree except unmasked window read/write bit.
// - Unsupported identifier-zero opcode in supervisor mode raises F-line.
// - Unsupported identifier-zero opcode in user mode raises privilege.
// - Nonzero coprocessor identifier goes to the coprocessor interface.
// - All four MMU operations are privileged, supervisor mode only.
// - Function code lookup indexes the top table by access code.
// - Supervisor root pointer in use: supervisor walks start from it.
// - Level-zero probe sets transparent bit on any window match.
package mmu_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] OFF_CRP_HI  = 8'h00;
	localparam logic [7:0] OFF_CRP_LO  = 8'h04;
	localparam logic [7:0] OFF_SRP_HI  = 8'h08;
	localparam logic [7:0] OFF_SRP_LO  = 8'h0c;
	localparam logic [7:0] OFF_TC      = 8'h10;
	localparam logic [7:0] OFF_TT0     = 8'h14;
	localparam logic [7:0] OFF_TT1     = 8'h18;
	localparam logic [7:0] OFF_STATUS  = 8'h1c;
	localparam logic [7:0] OFF_CMD     = 8'h20;
	localparam logic [7:0] OFF_OPND_LO = 8'h24;
	localparam logic [7:0] OFF_OPND_HI = 8'h28;
	localparam logic [7:0] OFF_LADDR   = 8'h2c;
	localparam logic [7:0] OFF_RESULT  = 8'h30;
	localparam logic [7:0] OFF_DESC    = 8'h34;

	// ==========================================================
	// Field positions
	localparam int TC_E      = 31;
	localparam int TC_SRE    = 25;
	localparam int TC_FCL    = 24;
	localparam int TT_E      = 15;
	localparam int TT_RW     = 9;
	localparam int TT_RWM    = 8;
	localparam int ST_B      = 15;
	localparam int ST_L      = 14;
	localparam int ST_S      = 13;
	localparam int ST_W      = 11;
	localparam int ST_I      = 10;
	localparam int ST_M      = 9;
	localparam int ST_T      = 6;
	localparam int RES_BUSY  = 8;
	localparam logic [5:0] TC_TOTAL = 6'h20;
	localparam logic [3:0] PS_MIN   = 4'h8;
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;

	// ==========================================================
	// Operations, register selects, exception codes
	localparam logic [2:0] OP_MOVE    = 3'h0;
	localparam logic [2:0] OP_FLUSH   = 3'h1;
	localparam logic [2:0] OP_PRELOAD = 3'h2;
	localparam logic [2:0] OP_PROBE   = 3'h3;
	localparam logic [2:0] SEL_CRP    = 3'h0;
	localparam logic [2:0] SEL_SRP    = 3'h1;
	localparam logic [2:0] SEL_TC     = 3'h2;
	localparam logic [2:0] SEL_STATUS = 3'h3;
	localparam logic [2:0] SEL_TT0    = 3'h4;
	localparam logic [2:0] SEL_TT1    = 3'h5;
	localparam logic [1:0] FL_ALL     = 2'h0;
	localparam logic [1:0] FL_FC      = 2'h1;
	localparam logic [1:0] FL_FC_ADDR = 2'h2;
	localparam logic [2:0] EXC_NONE   = 3'h0;
	localparam logic [2:0] EXC_CONFIG = 3'h1;
	localparam logic [2:0] EXC_FLINE  = 3'h2;
	localparam logic [2:0] EXC_PRIV   = 3'h3;
	localparam logic [2:0] EXC_COPROC = 3'h4;

	typedef struct packed {
		logic [9:0] spare;
		logic [2:0] coprocessor_ident;
		logic       supervisor;
		logic       write_attr;
		logic [2:0] level;
		logic [2:0] fc;
		logic [1:0] flush_mode;
		logic       flush_inhibit;
		logic [2:0] reg_sel;
		logic       to_mmu;
		logic [2:0] op;
	} cmd_t;

	typedef struct packed {
		logic [63:0] root;
		logic        fc_index;
		logic [2:0]  fc;
		logic [31:0] laddr;
		logic        write_attr;
		logic [2:0]  level;
		logic        preload;
	} walk_req_t;

	typedef struct packed {
		logic [31:0] phys;
		logic [15:0] status;
		logic [31:0] desc_addr;
	} walk_rsp_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WALK = 2'b10
	} state_t;

endpackage : mmu_pkg

// File: mmu_control_atc_maintenance.sv
module mmu_control_atc_maintenance #(
	parameter int ENTRIES = 8
) (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	output logic                   walk_valid,
	output mmu_pkg::walk_req_t     walk_req,
	input  wire logic              walk_done,
	input  wire mmu_pkg::walk_rsp_t walk_rsp,
	output logic                   config_exc,
	output logic                   fline_exc,
	output logic                   priv_exc,
	output logic                   coproc_dispatch
);

	localparam int IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;

	// ==========================================================
	// Registers
	logic [63:0] cpu_root_pointer;
	logic [63:0] supervisor_root_pointer;
	logic [31:0] translation_control;
	logic [31:0] transparent_window_zero;
	logic [31:0] transparent_window_one;
	logic [15:0] translation_status;
	logic [31:0] opnd_lo;
	logic [31:0] opnd_hi;
	logic [31:0] laddr;
	logic [31:0] desc_addr;
	logic [2:0]  exc_code;
	mmu_pkg::cmd_t   cmd;
	mmu_pkg::state_t state;

	// ==========================================================
	// Bus slave
	logic       wr_pend;
	logic [7:0] wr_addr;
	logic       take;
	logic [7:0] ra;

	assign take = hsel && htrans[1] && hready;
	assign ra   = haddr[7:0];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend   <= 1'b0;
			wr_addr   <= 8'h00;
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end
		else
		begin
			// Zero wait states
			hreadyout <= 1'b1;
			wr_pend   <= take && hwrite;
			if (take)
				wr_addr <= haddr[7:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= mmu_pkg::RESET_WORD;
		else if (take && !hwrite)
		begin
			if (ra == mmu_pkg::OFF_CRP_HI)
				hrdata <= cpu_root_pointer[63:32];
			else if (ra == mmu_pkg::OFF_CRP_LO)
				hrdata <= cpu_root_pointer[31:0];
			else if (ra == mmu_pkg::OFF_SRP_HI)
				hrdata <= supervisor_root_pointer[63:32];
			else if (ra == mmu_pkg::OFF_SRP_LO)
				hrdata <= supervisor_root_pointer[31:0];
			else if (ra == mmu_pkg::OFF_TC)
				hrdata <= translation_control;
			else if (ra == mmu_pkg::OFF_TT0)
				hrdata <= transparent_window_zero;
			else if (ra == mmu_pkg::OFF_TT1)
				hrdata <= transparent_window_one;
			else if (ra == mmu_pkg::OFF_STATUS)
				hrdata <= {16'h0000, translation_status};
			else if (ra == mmu_pkg::OFF_CMD)
				hrdata <= {1'b0, cmd};
			else if (ra == mmu_pkg::OFF_OPND_LO)
				hrdata <= opnd_lo;
			else if (ra == mmu_pkg::OFF_OPND_HI)
				hrdata <= opnd_hi;
			else if (ra == mmu_pkg::OFF_LADDR)
				hrdata <= laddr;
			else if (ra == mmu_pkg::OFF_RESULT)
				hrdata <= {23'h000000, state == mmu_pkg::ST_WALK,
					5'h00, exc_code};
			else if (ra == mmu_pkg::OFF_DESC)
				hrdata <= desc_addr;
			else
				hrdata <= mmu_pkg::RESET_WORD;
		end
	end

	// ==========================================================
	// Command decode
	mmu_pkg::cmd_t new_cmd;
	logic issue;
	logic [2:0] next_exc;
	logic mv_wr;
	logic mv_rd;
	logic do_flush;
	logic probe0;
	logic start_walk;
	logic cfg_bad;

	assign new_cmd = mmu_pkg::cmd_t'(hwdata[30:0]);
	// Commands during a walk are dropped
	assign issue = wr_pend && wr_addr == mmu_pkg::OFF_CMD
		&& state == mmu_pkg::ST_IDLE;

	always_comb
	begin
		next_exc = mmu_pkg::EXC_NONE;
		if (new_cmd.coprocessor_ident != 3'h0)
			next_exc = mmu_pkg::EXC_COPROC;
		else if (!new_cmd.supervisor)
			next_exc = mmu_pkg::EXC_PRIV;
		else if (new_cmd.op > mmu_pkg::OP_PROBE)
			next_exc = mmu_pkg::EXC_FLINE;
	end

	logic ok;
	assign ok         = issue && next_exc == mmu_pkg::EXC_NONE;
	assign mv_wr      = ok && new_cmd.op == mmu_pkg::OP_MOVE && new_cmd.to_mmu;
	assign mv_rd      = ok && new_cmd.op == mmu_pkg::OP_MOVE && !new_cmd.to_mmu;
	assign probe0     = ok && new_cmd.op == mmu_pkg::OP_PROBE
		&& new_cmd.level == 3'h0;
	assign start_walk = ok && (new_cmd.op == mmu_pkg::OP_PRELOAD
		|| (new_cmd.op == mmu_pkg::OP_PROBE && new_cmd.level != 3'h0));
	assign do_flush   = mv_wr && !new_cmd.flush_inhibit
		&& new_cmd.reg_sel != mmu_pkg::SEL_STATUS;

	// Index fields to the first zero, plus page size and shift
	function automatic logic [5:0] tc_sum(input logic [31:0] v);
		logic [5:0] s;
		logic       stop;
		s    = {2'b00, v[23:20]} + {2'b00, v[19:16]};
		stop = 1'b0;
		for (int k = 3; k >= 0; k--)
		begin
			if (v[k*4 +: 4] == 4'h0)
				stop = 1'b1;
			if (!stop)
				s = s + {2'b00, v[k*4 +: 4]};
		end
		return s;
	endfunction : tc_sum

	always_comb
	begin
		cfg_bad = 1'b0;
		if (new_cmd.reg_sel == mmu_pkg::SEL_TC)
			cfg_bad = opnd_lo[23:20] < mmu_pkg::PS_MIN
				|| (opnd_lo[mmu_pkg::TC_E]
				&& tc_sum(opnd_lo) != mmu_pkg::TC_TOTAL);
		else if (new_cmd.reg_sel == mmu_pkg::SEL_CRP
			|| new_cmd.reg_sel == mmu_pkg::SEL_SRP)
			cfg_bad = opnd_hi[1:0] == 2'b00;
	end

	// Pulses follow the write, so the new value is visible
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			exc_code        <= mmu_pkg::EXC_NONE;
			config_exc      <= 1'b0;
			fline_exc       <= 1'b0;
			priv_exc        <= 1'b0;
			coproc_dispatch <= 1'b0;
		end
		else
		begin
			config_exc      <= mv_wr && cfg_bad;
			fline_exc       <= issue && next_exc == mmu_pkg::EXC_FLINE;
			priv_exc        <= issue && next_exc == mmu_pkg::EXC_PRIV;
			coproc_dispatch <= issue && next_exc == mmu_pkg::EXC_COPROC;
			if (issue)
				exc_code <= (mv_wr && cfg_bad) ? mmu_pkg::EXC_CONFIG
					: next_exc;
		end
	end

	// ==========================================================
	// Register moves
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cpu_root_pointer        <= {2{mmu_pkg::RESET_WORD}};
			supervisor_root_pointer <= {2{mmu_pkg::RESET_WORD}};
			translation_control     <= mmu_pkg::RESET_WORD;
			transparent_window_zero <= mmu_pkg::RESET_WORD;
			transparent_window_one  <= mmu_pkg::RESET_WORD;
		end
		else if (mv_wr)
		begin
			case (new_cmd.reg_sel)
				mmu_pkg::SEL_CRP: cpu_root_pointer <= {opnd_hi, opnd_lo};
				mmu_pkg::SEL_SRP:
					supervisor_root_pointer <= {opnd_hi, opnd_lo};
				mmu_pkg::SEL_TC:  translation_control <= opnd_lo;
				mmu_pkg::SEL_TT0: transparent_window_zero <= opnd_lo;
				mmu_pkg::SEL_TT1: transparent_window_one <= opnd_lo;
				default: ;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			opnd_lo <= mmu_pkg::RESET_WORD;
			opnd_hi <= mmu_pkg::RESET_WORD;
			laddr   <= mmu_pkg::RESET_WORD;
			cmd     <= '0;
		end
		else
		begin
			if (issue)
				cmd <= new_cmd;
			if (wr_pend && wr_addr == mmu_pkg::OFF_LADDR)
				laddr <= hwdata;
			if (mv_rd)
			begin
				opnd_hi <= mmu_pkg::RESET_WORD;
				case (new_cmd.reg_sel)
					mmu_pkg::SEL_CRP:
						{opnd_hi, opnd_lo} <= cpu_root_pointer;
					mmu_pkg::SEL_SRP:
						{opnd_hi, opnd_lo} <= supervisor_root_pointer;
					mmu_pkg::SEL_TC:     opnd_lo <= translation_control;
					mmu_pkg::SEL_STATUS: opnd_lo <= {16'h0000, translation_status};
					mmu_pkg::SEL_TT0:    opnd_lo <= transparent_window_zero;
					mmu_pkg::SEL_TT1:    opnd_lo <= transparent_window_one;
					default:             opnd_lo <= mmu_pkg::RESET_WORD;
				endcase
			end
			else
			begin
				if (wr_pend && wr_addr == mmu_pkg::OFF_OPND_LO)
					opnd_lo <= hwdata;
				if (wr_pend && wr_addr == mmu_pkg::OFF_OPND_HI)
					opnd_hi <= hwdata;
			end
		end
	end

	// ==========================================================
	// Translation cache
	// No reset, so a reset never flushes the cache
	logic              c_valid [ENTRIES];
	logic [2:0]        c_fc    [ENTRIES];
	logic [19:0]       c_tag   [ENTRIES];
	logic [19:0]       c_phys  [ENTRIES];
	logic              c_berr  [ENTRIES];
	logic              c_wp    [ENTRIES];
	logic              c_mod   [ENTRIES];
	logic [ENTRIES-1:0] fc_hit;
	logic [ENTRIES-1:0] addr_hit;
	logic [IW-1:0]     rr_ptr;
	logic [2:0]        op_fc;
	logic [31:0]       op_la;

	// Probe and flush use the new command, install the held one
	assign op_fc = (state == mmu_pkg::ST_WALK) ? cmd.fc : new_cmd.fc;
	assign op_la = laddr;

	for (genvar g = 0; g < ENTRIES; g++)
	begin : g_match
		assign fc_hit[g]   = c_valid[g] && c_fc[g] == op_fc;
		assign addr_hit[g] = fc_hit[g] && c_tag[g] == op_la[31:12];
	end

	logic install;
	assign install = state == mmu_pkg::ST_WALK && walk_done && walk_req.preload;

	always_ff @(posedge hclk)
	begin
		for (int i = 0; i < ENTRIES; i++)
		begin
			if (do_flush)
				c_valid[i] <= 1'b0;
			else if (ok && new_cmd.op == mmu_pkg::OP_FLUSH)
			begin
				if (new_cmd.flush_mode == mmu_pkg::FL_ALL
					|| (new_cmd.flush_mode == mmu_pkg::FL_FC && fc_hit[i])
					|| (new_cmd.flush_mode == mmu_pkg::FL_FC_ADDR
					&& addr_hit[i]))
					c_valid[i] <= 1'b0;
			end
			else if (install)
			begin
				// Refill drops any older entry for the address
				if (addr_hit[i] && IW'(i) != rr_ptr)
					c_valid[i] <= 1'b0;
				if (IW'(i) == rr_ptr)
				begin
					c_valid[i] <= 1'b1;
					c_fc[i]    <= cmd.fc;
					c_tag[i]   <= laddr[31:12];
					c_phys[i]  <= walk_rsp.phys[31:12];
					c_berr[i]  <= walk_rsp.status[mmu_pkg::ST_B];
					c_wp[i]    <= walk_rsp.status[mmu_pkg::ST_W];
					c_mod[i]   <= walk_rsp.status[mmu_pkg::ST_M];
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rr_ptr <= '0;
		else if (install)
			rr_ptr <= (rr_ptr == IW'(ENTRIES - 1)) ? '0 : rr_ptr + 1'b1;
	end

	// ==========================================================
	// Level-zero probe
	function automatic logic tt_match(input logic [31:0] tt,
		input logic [2:0] fc, input logic [31:0] la, input logic wr);
		return tt[mmu_pkg::TT_E]
			&& ((tt[31:24] ^ la[31:24]) & ~tt[23:16]) == 8'h00
			&& ((tt[6:4] ^ fc) & ~tt[2:0]) == 3'h0
			&& (tt[mmu_pkg::TT_RWM] || tt[mmu_pkg::TT_RW] == !wr);
	endfunction : tt_match

	logic [15:0] probe_status;
	always_comb
	begin
		probe_status = 16'h0000;
		probe_status[mmu_pkg::ST_I] = 1'b1;
		if (tt_match(transparent_window_zero, new_cmd.fc, laddr,
				new_cmd.write_attr)
			|| tt_match(transparent_window_one, new_cmd.fc, laddr,
				new_cmd.write_attr))
			probe_status = 16'h0040;
		else
			for (int i = ENTRIES - 1; i >= 0; i--)
				if (addr_hit[i])
				begin
					probe_status = 16'h0000;
					probe_status[mmu_pkg::ST_B] = c_berr[i];
					probe_status[mmu_pkg::ST_I] = c_berr[i];
					probe_status[mmu_pkg::ST_W] = c_wp[i];
					probe_status[mmu_pkg::ST_M] = c_mod[i];
				end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			translation_status <= 16'h0000;
			desc_addr          <= mmu_pkg::RESET_WORD;
		end
		else if (mv_wr && new_cmd.reg_sel == mmu_pkg::SEL_STATUS)
			translation_status <= opnd_lo[15:0];
		else if (probe0)
			translation_status <= probe_status;
		else if (state == mmu_pkg::ST_WALK && walk_done && !walk_req.preload)
		begin
			translation_status <= walk_rsp.status;
			desc_addr          <= walk_rsp.desc_addr;
		end
	end

	// ==========================================================
	// Table walk sequencing
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state      <= mmu_pkg::ST_IDLE;
			walk_valid <= 1'b0;
			walk_req   <= '0;
		end
		else
		begin
			case (state)
				mmu_pkg::ST_IDLE:
					if (start_walk)
					begin
						state      <= mmu_pkg::ST_WALK;
						walk_valid <= 1'b1;
						walk_req.root <= (translation_control[mmu_pkg::TC_SRE]
							&& new_cmd.fc[2]) ? supervisor_root_pointer
							: cpu_root_pointer;
						walk_req.fc_index <=
							translation_control[mmu_pkg::TC_FCL];
						walk_req.fc         <= new_cmd.fc;
						walk_req.laddr      <= laddr;
						walk_req.write_attr <= new_cmd.write_attr;
						walk_req.level      <= new_cmd.level;
						walk_req.preload    <= new_cmd.op == mmu_pkg::OP_PRELOAD;
					end
				mmu_pkg::ST_WALK:
					if (walk_done)
					begin
						state      <= mmu_pkg::ST_IDLE;
						walk_valid <= 1'b0;
					end
				default:
				begin
					state      <= mmu_pkg::ST_IDLE;
					walk_valid <= 1'b0;
				end
			endcase
		end
	end

endmodule : mmu_control_atc_maintenance

// File: mmu_control_monitor.sv
module mmu_control_monitor (
	input wire logic               hclk,
	input wire logic               hresetn,
	input wire logic               hsel,
	input wire logic [31:0]        haddr,
	input wire logic [1:0]         htrans,
	input wire logic               hwrite,
	input wire logic [31:0]        hwdata,
	input wire logic               hready,
	input wire logic               walk_valid,
	input wire mmu_pkg::walk_req_t walk_req,
	input wire logic               walk_done,
	input wire logic               config_exc,
	input wire logic               fline_exc,
	input wire logic               priv_exc,
	input wire logic               coproc_dispatch
);
	// ==========================================
	// Command data phase tracking
	logic          cmd_dp;
	mmu_pkg::cmd_t c;
	mmu_pkg::cmd_t held;
	assign c = mmu_pkg::cmd_t'(hwdata[30:0]);
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cmd_dp <= 1'b0;
			held <= '0;
		end
		else
		begin
			if (hready)
				cmd_dp <= hsel && htrans[1] && hwrite
					&& haddr[7:0] == mmu_pkg::OFF_CMD;
			if (cmd_dp)
				held <= c;
		end
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// Commands during a walk are dropped
	sequence s_take;
		cmd_dp && !walk_valid && c.coprocessor_ident == 3'h0;
	endsequence
	sequence s_walk;
		s_take ##0 c.supervisor && (c.op == mmu_pkg::OP_PRELOAD
			|| (c.op == mmu_pkg::OP_PROBE && c.level != 3'h0));
	endsequence
	AST_PRIV: assert property (
		s_take ##0 !c.supervisor |=> priv_exc && !walk_valid)
		else $error("priv missing");
	AST_FLINE: assert property (
		s_take ##0 c.supervisor && c.op > mmu_pkg::OP_PROBE
		|=> fline_exc && !priv_exc)
		else $error("fline missing");
	AST_COPROC: assert property (
		cmd_dp && !walk_valid && c.coprocessor_ident != 3'h0
		|=> coproc_dispatch && !fline_exc && !priv_exc && !walk_valid)
		else $error("coproc missing");
	AST_WALK: assert property (
		s_walk |=> walk_valid
		&& walk_req.preload == (held.op == mmu_pkg::OP_PRELOAD))
		else $error("walk not started");
	AST_WATTR: assert property (
		s_walk |=> walk_req.write_attr == held.write_attr
		&& walk_req.fc == held.fc)
		else $error("walk attribute wrong");
	AST_LEVEL: assert property (
		s_take ##0 c.supervisor && c.op == mmu_pkg::OP_PROBE
		&& c.level == 3'h7 |=> walk_req.level == 3'h7 && !walk_req.preload)
		else $error("level wrong");
	AST_HOLD: assert property (
		walk_valid && !walk_done |=> walk_valid && $stable(walk_req))
		else $error("walk request moved");
	AST_END: assert property (
		walk_valid && walk_done |=> !walk_valid)
		else $error("walk did not end");
	AST_EXC: assert property (
		config_exc || fline_exc || priv_exc || coproc_dispatch
		|-> $past(cmd_dp))
		else $error("stray exception");
endmodule : mmu_control_monitor

bind mmu_control_atc_maintenance mmu_control_monitor i_mon (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
	.walk_valid(walk_valid), .walk_req(walk_req), .walk_done(walk_done),
	.config_exc(config_exc), .fline_exc(fline_exc),
	.priv_exc(priv_exc), .coproc_dispatch(coproc_dispatch));

// File: testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================
	// Harness
	localparam logic [31:0] LA = 32'h0040_0000;
	localparam logic [31:0] LB = 32'h0041_3000;
	logic               hclk = 1'b0;
	logic               hresetn = 1'b0;
	logic               hsel = 1'b0;
	logic [31:0]        haddr = 32'h0;
	logic [1:0]         htrans = 2'h0;
	logic               hwrite = 1'b0;
	logic [31:0]        hwdata = 32'h0;
	logic [31:0]        hrdata;
	logic               hreadyout;
	logic               walk_valid;
	logic               walk_done = 1'b0;
	logic [3:0]         exc;
	logic [31:0]        x;
	mmu_pkg::walk_req_t req;
	mmu_pkg::walk_req_t seen;
	mmu_pkg::walk_rsp_t rsp = '0;
	mmu_pkg::cmd_t      c;
	int                 bad_count = 0;
	int                 compares = 0;
	always #12.5 hclk = ~hclk;
	mmu_control_atc_maintenance i_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(), .walk_valid(walk_valid), .walk_req(req),
		.walk_done(walk_done), .walk_rsp(rsp), .config_exc(exc[3]),
		.fline_exc(exc[2]), .priv_exc(exc[1]), .coproc_dispatch(exc[0]));
	// ==========================================
	// Shared tasks
	task automatic give_verdict;
		$display("Compares %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic check(string w, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask : check
	task automatic edge_rdy;
		int n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1)
		begin
			bad_count++;
			give_verdict();
		end
	endtask : edge_rdy
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		edge_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		edge_rdy();
		x = hrdata;
	endtask : bus
	task automatic rdc(string w, logic [7:0] a, logic [31:0] m,
		logic [31:0] e);
		bus(1'b0, a, 32'h0);
		check(w, e, x & m);
	endtask : rdc
	function automatic mmu_pkg::cmd_t mk(logic [2:0] op, logic [2:0] fc,
		logic [2:0] lv, logic wa);
		mk = '0;
		mk.op = op;
		mk.fc = fc;
		mk.level = lv;
		mk.write_attr = wa;
		mk.supervisor = 1'b1;
	endfunction : mk
	// Exception pulses stand one cycle after the command
	task automatic do_cmd(mmu_pkg::cmd_t cc, logic [3:0] e);
		bus(1'b1, mmu_pkg::OFF_CMD, {1'b0, cc});
		@(negedge hclk);
		check("exc", {28'h0, e}, {28'h0, exc});
	endtask : do_cmd
	// Walker answers late; idle lines carry inverted data
	task automatic serve(logic [15:0] st, logic [31:0] da);
		int n = 0;
		while (walk_valid !== 1'b1 && n < 64)
		begin
			@(negedge hclk);
			n++;
		end
		check("walk", 32'h1, {31'h0, walk_valid});
		seen = req;
		repeat (3) @(posedge hclk);
		walk_done <= 1'b1;
		rsp <= {~da, st, da};
		@(posedge hclk);
		walk_done <= 1'b0;
		rsp <= {da, ~st, ~da};
	endtask : serve
	task automatic preload(logic [31:0] la, logic [2:0] fc, logic wa);
		bus(1'b1, mmu_pkg::OFF_LADDR, la);
		do_cmd(mk(mmu_pkg::OP_PRELOAD, fc, 3'h0, wa), 4'h0);
		serve(16'h0a00, la ^ 32'h0000_0ff0);
	endtask : preload
	task automatic resident(logic [31:0] la, logic [2:0] fc, logic gone);
		bus(1'b1, mmu_pkg::OFF_LADDR, la);
		do_cmd(mk(mmu_pkg::OP_PROBE, fc, 3'h0, 1'b0), 4'h0);
		rdc("absent", mmu_pkg::OFF_STATUS, 32'h1 << mmu_pkg::ST_I,
			{31'h0, gone} << mmu_pkg::ST_I);
	endtask : resident
	task automatic mv(logic [2:0] s, logic [31:0] hi, logic [31:0] lo,
		logic fd, logic [3:0] e);
		bus(1'b1, mmu_pkg::OFF_OPND_HI, hi);
		bus(1'b1, mmu_pkg::OFF_OPND_LO, lo);
		c = mk(mmu_pkg::OP_MOVE, 3'h0, 3'h0, 1'b0);
		c.to_mmu = 1'b1;
		c.reg_sel = s;
		c.flush_inhibit = fd;
		do_cmd(c, e);
	endtask : mv
	// ==========================================
	// Scenarios
	task automatic t_flush;
		c = mk(mmu_pkg::OP_FLUSH, 3'h5, 3'h0, 1'b0);
		do_cmd(c, 4'h0);
		resident(LA, 3'h5, 1'b1);
		preload(LA, 3'h5, 1'b1);
		preload(LB, 3'h5, 1'b0);
		preload(LA, 3'h1, 1'b0);
		bus(1'b1, mmu_pkg::OFF_LADDR, LA);
		c.flush_mode = mmu_pkg::FL_FC_ADDR;
		do_cmd(c, 4'h0);
		resident(LA, 3'h5, 1'b1);
		resident(LB, 3'h5, 1'b0);
		c.flush_mode = mmu_pkg::FL_FC;
		do_cmd(c, 4'h0);
		resident(LB, 3'h5, 1'b1);
		resident(LA, 3'h1, 1'b0);
		c.flush_mode = mmu_pkg::FL_ALL;
		do_cmd(c, 4'h0);
		resident(LA, 3'h1, 1'b1);
	endtask : t_flush
	task automatic t_preload;
		logic [31:0] s0;
		bus(1'b0, mmu_pkg::OFF_STATUS, 32'h0);
		s0 = x;
		preload(LA, 3'h5, 1'b1);
		check("write attr", 32'h1, {31'h0, seen.write_attr});
		check("address", LA, seen.laddr);
		rdc("status kept", mmu_pkg::OFF_STATUS, 32'hffff, s0 & 32'hffff);
		preload(LB, 3'h5, 1'b0);
		check("read attr", 32'h0, {31'h0, seen.write_attr});
		resident(LA, 3'h5, 1'b0);
	endtask : t_preload
	task automatic t_move;
		logic [2:0] s [5] = '{mmu_pkg::SEL_CRP, mmu_pkg::SEL_SRP,
			mmu_pkg::SEL_TC, mmu_pkg::SEL_TT0, mmu_pkg::SEL_TT1};
		logic [7:0] o [5] = '{mmu_pkg::OFF_CRP_LO, mmu_pkg::OFF_SRP_LO,
			mmu_pkg::OFF_TC, mmu_pkg::OFF_TT0, mmu_pkg::OFF_TT1};
		logic [31:0] v;
		for (int i = 0; i < 5; i++)
		begin
			v = (i == 2) ? 32'h00c0_0000 : 32'h0123_4560 + 32'(i);
			preload(LA, 3'h5, 1'b0);
			mv(s[i], 32'h0000_0002, v, 1'b1, 4'h0);
			resident(LA, 3'h5, 1'b0);
			mv(s[i], 32'h0000_0002, v, 1'b0, 4'h0);
			resident(LA, 3'h5, 1'b1);
			rdc("register", o[i], 32'hffff_ffff, v);
		end
	endtask : t_move
	// Control word: enable 31, page 23:20, shift 19:16, index below
	task automatic t_config;
		logic [31:0] w [6] = '{32'h80c0_aa00, 32'h80c0_a900,
			32'h80c0_aa05, 32'h8084_aa00, 32'h0070_0000, 32'h8075_aa00};
		logic [3:0] e [6] = '{4'h0, 4'h8, 4'h0, 4'h0, 4'h8, 4'h8};
		for (int i = 0; i < 6; i++)
			mv(mmu_pkg::SEL_TC, 32'h0, w[i], 1'b1, e[i]);
		mv(mmu_pkg::SEL_CRP, 32'h0000_0a50, 32'h7000, 1'b1, 4'h8);
		rdc("root stored", mmu_pkg::OFF_CRP_HI, '1, 32'h0000_0a50);
		mv(mmu_pkg::SEL_SRP, 32'h0000_0b54, 32'h7000, 1'b1, 4'h8);
		rdc("root stored", mmu_pkg::OFF_SRP_HI, '1, 32'h0000_0b54);
	endtask : t_config
	task automatic t_roots;
		mv(mmu_pkg::SEL_CRP, 32'h2, 32'hc000_0000, 1'b0, 4'h0);
		mv(mmu_pkg::SEL_SRP, 32'h2, 32'h5000_0000, 1'b0, 4'h0);
		mv(mmu_pkg::SEL_TC, 32'h0, 32'h03c0_0000, 1'b0, 4'h0);
		preload(LA, 3'h5, 1'b0);
		check("root", 32'h5000_0000, seen.root[31:0]);
		check("fc index", 32'h1, {31'h0, seen.fc_index});
		preload(LA, 3'h1, 1'b0);
		check("root", 32'hc000_0000, seen.root[31:0]);
		mv(mmu_pkg::SEL_TC, 32'h0, 32'h00c0_0000, 1'b0, 4'h0);
		preload(LA, 3'h5, 1'b0);
		check("root", 32'hc000_0000, seen.root[31:0]);
		check("fc index", 32'h0, {31'h0, seen.fc_index});
	endtask : t_roots
	task automatic t_probe;
		bus(1'b1, mmu_pkg::OFF_LADDR, LB);
		do_cmd(mk(mmu_pkg::OP_PROBE, 3'h1, 3'h7, 1'b1), 4'h0);
		serve(16'h8c40, 32'h0000_3ff0);
		check("level", 32'h7, {29'h0, seen.level});
		rdc("status", mmu_pkg::OFF_STATUS, 32'hffff, 32'h8c40);
		rdc("descriptor", mmu_pkg::OFF_DESC, '1, 32'h3ff0);
		resident(LB, 3'h1, 1'b1);
	endtask : t_probe
	task automatic t_illegal;
		for (int i = 0; i < 8; i++)
		begin
			c = mk(3'(i), 3'h5, 3'h7, 1'b0);
			c.supervisor = 1'b0;
			do_cmd(c, 4'h2);
			check("no walk", 32'h0, {31'h0, walk_valid});
			c.supervisor = 1'b1;
			if (i > 3)
				do_cmd(c, 4'h4);
		end
		c.coprocessor_ident = 3'h1;
		do_cmd(c, 4'h1);
		c.coprocessor_ident = 3'h7;
		c.op = mmu_pkg::OP_PRELOAD;
		do_cmd(c, 4'h1);
		check("no walk", 32'h0, {31'h0, walk_valid});
	endtask : t_illegal
	task automatic t_reset;
		mv(mmu_pkg::SEL_TC, 32'h0, 32'h80c0_aa00, 1'b0, 4'h0);
		mv(mmu_pkg::SEL_TT0, 32'h0, 32'hff00_8000, 1'b0, 4'h0);
		mv(mmu_pkg::SEL_TT1, 32'h0, 32'hfe00_8000, 1'b0, 4'h0);
		preload(LA, 3'h5, 1'b0);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rdc("enable", mmu_pkg::OFF_TC, 32'h8000_0000, 32'h0);
		rdc("window", mmu_pkg::OFF_TT0, 32'h0000_8000, 32'h0);
		rdc("window", mmu_pkg::OFF_TT1, 32'h0000_8000, 32'h0);
		resident(LA, 3'h5, 1'b0);
	endtask : t_reset
	initial
	begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		t_flush();
		t_preload();
		t_move();
		t_config();
		t_roots();
		t_probe();
		t_illegal();
		t_reset();
		give_verdict();
	end
endmodule : testbench
